// ===== esr_pkg.sv
// esr_pkg: constants and types shared by the status-reporting bank
// assumes a single 100 MHz clock and a synchronous active-high reset
package esr_pkg;
    // ----------------------------------------------------------------
    // register selectors for the query/command port
    // ----------------------------------------------------------------
    localparam logic [2:0] ESR_SEL_EVT = 3'h0; // event status register
    localparam logic [2:0] ESR_SEL_ENA = 3'h1; // event status enable mask
    localparam logic [2:0] ESR_SEL_OPC = 3'h2; // operation condition
    localparam logic [2:0] ESR_SEL_OPE = 3'h3; // operation event
    localparam logic [2:0] ESR_SEL_QUC = 3'h4; // questionable condition
    localparam logic [2:0] ESR_SEL_QUE = 3'h5; // questionable event
    localparam logic [2:0] ESR_SEL_OPN = 3'h6; // operation enable
    localparam logic [2:0] ESR_SEL_QUN = 3'h7; // questionable enable
    // ----------------------------------------------------------------
    // event status bit positions
    // ----------------------------------------------------------------
    localparam int ESR_B_OPC = 0; // operation complete
    localparam int ESR_B_QRY = 2; // query error
    localparam int ESR_B_DEV = 3; // device-dependent error
    localparam int ESR_B_EXE = 4; // execution error
    localparam int ESR_B_CMD = 5; // command error
    localparam int ESR_B_PON = 7; // power on
    // ----------------------------------------------------------------
    // operation / questionable bit positions and used-bit masks
    // ----------------------------------------------------------------
    localparam int ESR_O_CAL = 0;  // calibrating
    localparam int ESR_Q_BAT = 2;  // battery low
    localparam int ESR_Q_TMP = 4;  // temperature
    localparam int ESR_Q_LIM = 9;  // limit violated
    localparam int ESR_Q_UNA = 10; // unaligned measurement
    localparam logic [7:0] ESR_EVT_USED = 8'hBD;
    localparam logic [15:0] ESR_OP_USED = 16'h0001;
    localparam logic [15:0] ESR_QU_USED = 16'h0614;
    // ----------------------------------------------------------------
    // reset values and status byte positions
    // ----------------------------------------------------------------
    localparam logic [7:0] ESR_EVT_RST = 8'h80; // power-on recorded
    localparam logic [15:0] ESR_ZERO16 = 16'h0000;
    localparam int ESR_SB_QUE = 3; // questionable summary
    localparam int ESR_SB_ESB = 5; // event summary
    localparam int ESR_SB_OPR = 7; // operation summary
    // error queue code ranges
    localparam logic signed [15:0] ESR_ERR_DEV = -16'sd300;
    localparam logic signed [15:0] ESR_ERR_EXE = -16'sd200;
    localparam logic signed [15:0] ESR_ERR_CMD = -16'sd100;
    // ----------------------------------------------------------------
    // operation-complete tracker states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {ESR_IDLE, ESR_WAIT} esr_opc_t;
endpackage : esr_pkg

// ===== esr_evt_latch.sv
// esr_evt_latch: one sticky event register with read-to-clear
// assumes sources are synchronous; set wins over a clear in one cycle
`timescale 1ns/1ns
`default_nettype none
module esr_evt_latch #(
    parameter int W = 16,
    parameter logic [W-1:0] USED = '1,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] set_i,    // one-cycle set pulses
    input wire logic clr_i,            // read of this register
    output logic [W-1:0] evt_o         // latched events
);
    logic [W-1:0] evt_r;
    logic [W-1:0] evt_nxt;
    // elaboration guard: the bank never carries registers above 16 bits
    if (W < 1 || W > 16) begin : g_bad_width
        $error("esr_evt_latch: W must lie between 1 and 16");
    end
    // ----------------------------------------------------------------
    // next value: clear on read, but a new set survives the clear
    // ----------------------------------------------------------------
    always_comb begin
        evt_nxt = clr_i ? '0 : evt_r;
        evt_nxt = (evt_nxt | set_i) & USED;
    end
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            evt_r <= RST;
        end else begin
            evt_r <= evt_nxt;
        end
    end
    assign evt_o = evt_r;
    a_set_sticks: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        (set_i & USED) != '0 |=>
        (evt_r & $past(set_i) & USED) == ($past(set_i) & USED))
        else $error("event set lost");
    a_read_clears: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        clr_i && set_i == '0 |=> evt_r == '0)
        else $error("read did not clear");
endmodule : esr_evt_latch
`default_nettype wire

// ===== esr_status_bank.sv
// esr_status_bank: event status, operation and questionable registers
// assumes a command decoder turns queries into one-cycle read strobes
// Notes on behaviour
// - opc sets bit0 once earlier commands finish
// - query error sets event bit 2
// - device error sets bit 3, queues dev_code_i unchanged
// - execution error sets bit 4, queues -2xx
// - command error sets bit 5, queues -1xx
// - power-on sets event bit 7
// - event status register readable by query
// - enable mask writable and readable back
// - operation has condition and event parts
// - bit 0 high while calibrating only
// - bit 15 always reads zero
// - questionable condition and event each readable
// - battery low while on battery sets questionable bit 2
// - temperature sets questionable bit 4
// - limit violation sets questionable bit 9
// - unaligned measurement sets bit 10, indicator
// - summary bit 5 from enabled events
// - summary bit 7 from operation events
// - summary bit 3 from questionable events
`timescale 1ns/1ns
`default_nettype none
module esr_status_bank (
    input wire logic mclk_i,
    input wire logic rst_i,
    // command side
    input wire logic opc_cmd_i,        // operation-complete command
    input wire logic cmds_busy_i,      // earlier commands still running
    input wire logic query_err_i,      // unrequested read or abandoned
    input wire logic dev_err_i,        // device-dependent failure
    input wire logic [15:0] dev_code_i, // device error number
    input wire logic exe_err_i,        // valid but not executable
    input wire logic [7:0] exe_sub_i,  // offset within -2xx range
    input wire logic cmd_err_i,        // undefined or malformed
    input wire logic [7:0] cmd_sub_i,  // offset within -1xx range
    // register access
    input wire logic rd_i,             // one-cycle query strobe
    input wire logic wr_i,             // one-cycle set strobe
    input wire logic [2:0] sel_i,      // esr_pkg::ESR_SEL_* selector
    input wire logic [15:0] wdata_i,   // write data
    output logic [15:0] rdata_o,       // query answer
    output logic rvalid_o,             // answer valid pulse
    // instrument conditions
    input wire logic calibrating_i,    // calibration running
    input wire logic on_battery_i,     // no external supply
    input wire logic batt_low_i,       // charge below about 5%
    input wire logic temp_bad_i,       // questionable temperature
    input wire logic limit_fail_i,     // limit value violated
    input wire logic unaligned_i,      // measuring without alignment
    output logic unaligned_indicator_o, // user-visible warning
    // error queue push
    output logic err_push_o,           // push pulse
    output logic [15:0] err_code_o,    // signed error number
    // status byte summary bits
    output logic [7:0] stb_sum_o       // bits 3, 5, 7 only
);
    import esr_pkg::*;
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [7:0] ena_r, ena_nxt;        // event enable mask
    logic [15:0] open_r, open_nxt;     // operation enable
    logic [15:0] quen_r, quen_nxt;     // questionable enable
    logic [15:0] rdata_r, rdata_nxt;   // answer register
    logic rvalid_r, rvalid_nxt;
    logic push_r, push_nxt;
    logic [15:0] code_r, code_nxt;
    logic [15:0] opcond_r, opcond_nxt; // operation condition
    logic [15:0] qucond_r, qucond_nxt; // questionable condition
    logic [15:0] opcond_q, qucond_q;   // previous conditions for edges
    logic [7:0] evt_set;               // event status set pulses
    logic [15:0] op_set, qu_set;       // rising-condition pulses
    logic [7:0] evt;                   // latched event status
    logic [15:0] op_evt, qu_evt;       // latched event parts
    logic opc_fire;                    // operation complete reached
    esr_opc_t st_r, st_nxt;            // opc tracker
    // ----------------------------------------------------------------
    // read-clear decode shared by the three event parts
    // ----------------------------------------------------------------
    function automatic logic rd_hit(input logic rd, input logic [2:0] s,
                                    input logic [2:0] want);
        rd_hit = rd && (s == want);
    endfunction : rd_hit
    // ----------------------------------------------------------------
    // operation-complete tracker: waits for earlier commands to drain
    // ----------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        opc_fire = 1'b0;
        case (st_r)
            ESR_IDLE: begin
                if (opc_cmd_i && !cmds_busy_i) begin
                    opc_fire = 1'b1;
                end else if (opc_cmd_i) begin
                    st_nxt = ESR_WAIT;
                end
            end
            ESR_WAIT: begin
                if (!cmds_busy_i) begin
                    opc_fire = 1'b1;
                    st_nxt = ESR_IDLE;
                end
            end
            default: st_nxt = ESR_IDLE;
        endcase
    end
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            st_r <= ESR_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end
    // ----------------------------------------------------------------
    // event status set sources; power-on comes from the reset value
    // ----------------------------------------------------------------
    always_comb begin
        evt_set = 8'h00;
        evt_set[ESR_B_OPC] = opc_fire;
        evt_set[ESR_B_QRY] = query_err_i;
        evt_set[ESR_B_DEV] = dev_err_i;
        evt_set[ESR_B_EXE] = exe_err_i;
        evt_set[ESR_B_CMD] = cmd_err_i;
    end
    // ----------------------------------------------------------------
    // conditions: registered live levels, used bits only
    // ----------------------------------------------------------------
    always_comb begin
        opcond_nxt = ESR_ZERO16;
        opcond_nxt[ESR_O_CAL] = calibrating_i;
        qucond_nxt = ESR_ZERO16;
        qucond_nxt[ESR_Q_BAT] = on_battery_i && batt_low_i;
        qucond_nxt[ESR_Q_TMP] = temp_bad_i;
        qucond_nxt[ESR_Q_LIM] = limit_fail_i;
        qucond_nxt[ESR_Q_UNA] = unaligned_i;
        // event parts record positive transitions of the condition
        op_set = opcond_r & ~opcond_q;
        qu_set = qucond_r & ~qucond_q;
    end
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            opcond_r <= ESR_ZERO16;
            qucond_r <= ESR_ZERO16;
            opcond_q <= ESR_ZERO16;
            qucond_q <= ESR_ZERO16;
        end else begin
            opcond_r <= opcond_nxt;
            qucond_r <= qucond_nxt;
            opcond_q <= opcond_r;
            qucond_q <= qucond_r;
        end
    end
    // ----------------------------------------------------------------
    // sticky event parts, cleared by their own query
    // ----------------------------------------------------------------
    esr_evt_latch #(.W(8), .USED(ESR_EVT_USED), .RST(ESR_EVT_RST)) u_evt (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .set_i(evt_set),
        .clr_i(rd_hit(rd_i, sel_i, ESR_SEL_EVT)),
        .evt_o(evt)
    );
    esr_evt_latch #(.W(16), .USED(ESR_OP_USED), .RST(ESR_ZERO16)) u_op (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .set_i(op_set),
        .clr_i(rd_hit(rd_i, sel_i, ESR_SEL_OPE)),
        .evt_o(op_evt)
    );
    esr_evt_latch #(.W(16), .USED(ESR_QU_USED), .RST(ESR_ZERO16)) u_qu (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .set_i(qu_set),
        .clr_i(rd_hit(rd_i, sel_i, ESR_SEL_QUE)),
        .evt_o(qu_evt)
    );
    // ----------------------------------------------------------------
    // enable writes, query answers and error queue pushes
    // ----------------------------------------------------------------
    always_comb begin
        ena_nxt = ena_r;
        open_nxt = open_r;
        quen_nxt = quen_r;
        if (wr_i) begin
            case (sel_i)
                ESR_SEL_ENA: ena_nxt = wdata_i[7:0];
                ESR_SEL_OPN: open_nxt = wdata_i & ESR_OP_USED;
                ESR_SEL_QUN: quen_nxt = wdata_i & ESR_QU_USED;
                default: ena_nxt = ena_r; // other registers are read-only
            endcase
        end
        rvalid_nxt = rd_i;
        rdata_nxt = ESR_ZERO16;
        case (sel_i)
            ESR_SEL_EVT: rdata_nxt = {8'h00, evt};
            ESR_SEL_ENA: rdata_nxt = {8'h00, ena_r};
            ESR_SEL_OPC: rdata_nxt = opcond_r;
            ESR_SEL_OPE: rdata_nxt = op_evt;
            ESR_SEL_QUC: rdata_nxt = qucond_r;
            ESR_SEL_QUE: rdata_nxt = qu_evt;
            ESR_SEL_OPN: rdata_nxt = open_r;
            ESR_SEL_QUN: rdata_nxt = quen_r;
            default: rdata_nxt = ESR_ZERO16;
        endcase
        if (!rd_i) begin
            rdata_nxt = rdata_r; // hold the last answer between queries
        end
        rdata_nxt[15] = 1'b0;
        // one push per cycle; device error outranks execution, command
        push_nxt = dev_err_i || exe_err_i || cmd_err_i;
        if (dev_err_i) begin
            code_nxt = dev_code_i;
        end else if (exe_err_i) begin
            code_nxt = ESR_ERR_EXE - {8'h00, exe_sub_i};
        end else if (cmd_err_i) begin
            code_nxt = ESR_ERR_CMD - {8'h00, cmd_sub_i};
        end else begin
            code_nxt = code_r;
        end
    end
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            ena_r <= 8'h00;
            open_r <= ESR_ZERO16;
            quen_r <= ESR_ZERO16;
            rdata_r <= ESR_ZERO16;
            rvalid_r <= 1'b0;
            push_r <= 1'b0;
            code_r <= ESR_ZERO16;
        end else begin
            ena_r <= ena_nxt;
            open_r <= open_nxt;
            quen_r <= quen_nxt;
            rdata_r <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
            push_r <= push_nxt;
            code_r <= code_nxt;
        end
    end
    // ----------------------------------------------------------------
    // outputs and summary bits
    // ----------------------------------------------------------------
    assign rdata_o = rdata_r;
    assign rvalid_o = rvalid_r;
    assign err_push_o = push_r;
    assign err_code_o = code_r;
    assign unaligned_indicator_o = qucond_r[ESR_Q_UNA];
    always_comb begin
        stb_sum_o = 8'h00;
        stb_sum_o[ESR_SB_ESB] = |(evt & ena_r);
        stb_sum_o[ESR_SB_OPR] = |(op_evt & open_r);
        stb_sum_o[ESR_SB_QUE] = |(qu_evt & quen_r);
    end
    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    // completion is held back while busy, then recorded once drained
    sequence s_opc_wait;
        opc_cmd_i && cmds_busy_i && st_r == ESR_IDLE;
    endsequence
    sequence s_opc_drain;
        st_r == ESR_WAIT && !cmds_busy_i;
    endsequence
    a_opc_waits: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        s_opc_wait |-> !evt_set[ESR_B_OPC])
        else $error("opc before commands done");
    a_opc_done: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        s_opc_drain |=> evt[ESR_B_OPC])
        else $error("opc not recorded");
    a_qry_sets: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        query_err_i |=> evt[ESR_B_QRY]) else $error("query bit");
    a_dev_push: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        dev_err_i |=> err_push_o && evt[ESR_B_DEV] &&
        err_code_o == $past(dev_code_i)) else $error("device error push");
    a_exe_code: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        exe_err_i && !dev_err_i |=> err_push_o && evt[ESR_B_EXE] &&
        $signed(err_code_o) <= ESR_ERR_EXE) else $error("exe code");
    a_cmd_code: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        cmd_err_i && !dev_err_i && !exe_err_i |=> evt[ESR_B_CMD] &&
        $signed(err_code_o) <= ESR_ERR_CMD) else $error("cmd code");
    a_enable_back: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        wr_i && sel_i == ESR_SEL_ENA |=>
        {8'h00, ena_r} == ($past(wdata_i) & 16'h00FF))
        else $error("enable mask");
    a_op_event: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        opcond_r[ESR_O_CAL] && !opcond_q[ESR_O_CAL] |=> op_evt[ESR_O_CAL])
        else $error("operation event");
    a_cal_cond: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        1'b1 |=> opcond_r[ESR_O_CAL] == $past(calibrating_i))
        else $error("cal bit");
    a_bit15_zero: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        !rdata_o[15]) else $error("bit 15 set");
    a_batt_low: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        on_battery_i && batt_low_i |=> qucond_r[ESR_Q_BAT])
        else $error("battery bit");
    a_temp_cond: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        temp_bad_i |=> qucond_r[ESR_Q_TMP]) else $error("temperature");
    a_limit_cond: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        limit_fail_i |=> qucond_r[ESR_Q_LIM]) else $error("limit");
    a_unaligned: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        unaligned_i |=> unaligned_indicator_o) else $error("unaligned");
    a_esb_sum: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        stb_sum_o[ESR_SB_ESB] == ((evt & ena_r) != 8'h00))
        else $error("esb");
    a_opr_sum: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        stb_sum_o[ESR_SB_OPR] == ((op_evt & open_r) != ESR_ZERO16))
        else $error("operation summary");
    a_que_sum: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        stb_sum_o[ESR_SB_QUE] == ((qu_evt & quen_r) != ESR_ZERO16))
        else $error("questionable summary");
endmodule : esr_status_bank
`default_nettype wire

// ===== esr_ctrl_model.sv
// esr_ctrl_model: remote controller that issues set commands and queries
// assumes one clock; requests change at the falling edge only
`timescale 1ns/1ns
`default_nettype none
module esr_ctrl_model (
    input wire logic mclk_i,
    input wire logic [15:0] rdata_i, // query answer
    input wire logic rvalid_i, // answer valid pulse
    output logic rd_o, // query strobe
    output logic wr_o, // set strobe
    output logic [2:0] sel_o, // register selector
    output logic [15:0] wdata_o // set data
);
    // ----------------------------------------------------------------
    // access tasks
    // ----------------------------------------------------------------
    initial begin
        rd_o = 1'b0;
        wr_o = 1'b0;
        sel_o = 3'h0;
        wdata_o = 16'h0000;
    end
    // one-cycle set strobe; data is scrambled after the strobe
    task automatic wr_reg(input logic [2:0] s, input logic [15:0] d);
        @(negedge mclk_i);
        wr_o = 1'b1;
        sel_o = s;
        wdata_o = d;
        @(negedge mclk_i);
        wr_o = 1'b0;
        wdata_o = ~d;
    endtask : wr_reg
    // query with a bounded wait; a lost answer returns unknown
    task automatic rd_reg(input logic [2:0] s, output logic [15:0] v);
        int n;
        v = 16'hxxxx;
        @(negedge mclk_i);
        rd_o = 1'b1;
        sel_o = s;
        @(negedge mclk_i);
        rd_o = 1'b0;
        for (n = 0; n < 4; n++) begin
            if (rvalid_i === 1'b1) begin
                v = rdata_i;
                break;
            end
            @(negedge mclk_i);
        end
    endtask : rd_reg
endmodule : esr_ctrl_model
`default_nettype wire

// ===== esr_status_bank_tb_top.sv
// esr_status_bank_tb_top: directed register tests of the status bank
// assumes esr_pkg and the controller model are compiled first
`timescale 1ns/1ns
`default_nettype none
module esr_status_bank_tb_top;
    import esr_pkg::*;
    logic mclk_i, rst_i, opc, busy, qe, de, ee, ce, rd, wr, rv, una, push;
    logic cal, onb, bl, tmp, lim, una_o_w;
    logic [2:0] sel;
    logic [15:0] wd, rdat, code, v, dcode;
    logic [7:0] stb;
    int err_count, num_checks, cyc;
    // ----------------------------------------------------------------
    // clock, hang guard and instances
    // ----------------------------------------------------------------
    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            err_count = err_count + 1;
            end_of_test();
        end
    end
    esr_status_bank dut_u (.mclk_i(mclk_i), .rst_i(rst_i),
        .opc_cmd_i(opc), .cmds_busy_i(busy), .query_err_i(qe),
        .dev_err_i(de), .dev_code_i(dcode), .exe_err_i(ee),
        .exe_sub_i(8'h05), .cmd_err_i(ce), .cmd_sub_i(8'h07),
        .rd_i(rd), .wr_i(wr), .sel_i(sel), .wdata_i(wd), .rdata_o(rdat),
        .rvalid_o(rv), .calibrating_i(cal), .on_battery_i(onb),
        .batt_low_i(bl), .temp_bad_i(tmp), .limit_fail_i(lim),
        .unaligned_i(una), .unaligned_indicator_o(una_o_w),
        .err_push_o(push), .err_code_o(code), .stb_sum_o(stb));
    esr_ctrl_model ctl_u (.mclk_i(mclk_i), .rdata_i(rdat), .rvalid_i(rv),
        .rd_o(rd), .wr_o(wr), .sel_o(sel), .wdata_o(wd));
    // ----------------------------------------------------------------
    // compare, error pulse and closing tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks = num_checks + 1;
        if (seen !== exp) begin
            err_count = err_count + 1;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check
    // one-cycle error pulse; code checked once registered
    task automatic pulse(input int k);
        @(negedge mclk_i);
        {qe, de, ee, ce} = 4'h8 >> k;
        @(negedge mclk_i);
        {qe, de, ee, ce} = 4'h0;
    endtask : pulse
    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_of_test
    // ----------------------------------------------------------------
    // test sequence
    // ----------------------------------------------------------------
    initial begin
        err_count = 0;
        num_checks = 0;
        cyc = 0;
        rst_i = 1'b1;
        {opc, busy, qe, de, ee, ce, cal, onb, bl, tmp, lim, una} = '0;
        repeat (2) @(negedge mclk_i);
        rst_i = 1'b0;
        dcode = 16'hFED3;
        ctl_u.rd_reg(ESR_SEL_EVT, v);
        check(v, 16'h0080);
        ctl_u.rd_reg(ESR_SEL_EVT, v);
        check(v, 16'h0000);
        $display("test power-on done");
        pulse(0);
        check({15'h0000, push}, 16'h0000);
        pulse(1);
        check(code, 16'hFED3);
        check({15'h0000, push}, 16'h0001);
        pulse(2);
        check(code, 16'hFF33);
        pulse(3);
        check(code, 16'hFF95);
        dcode = 16'h0009;
        pulse(1);
        check(code, 16'h0009);
        ctl_u.rd_reg(ESR_SEL_EVT, v);
        check(v, 16'h003C);
        $display("test errors done");
        busy = 1'b1;
        @(negedge mclk_i) opc = 1'b1;
        @(negedge mclk_i) opc = 1'b0;
        ctl_u.rd_reg(ESR_SEL_EVT, v);
        check(v, 16'h0000);
        busy = 1'b0;
        repeat (2) @(negedge mclk_i);
        ctl_u.rd_reg(ESR_SEL_EVT, v);
        check(v, 16'h0001);
        @(negedge mclk_i) opc = 1'b1;
        @(negedge mclk_i) opc = 1'b0;
        ctl_u.rd_reg(ESR_SEL_EVT, v);
        check(v, 16'h0001);
        $display("test completion done");
        ctl_u.wr_reg(ESR_SEL_ENA, 16'h0020);
        ctl_u.rd_reg(ESR_SEL_ENA, v);
        check(v, 16'h0020);
        pulse(3);
        check({8'h00, stb}, 16'h0020);
        ctl_u.rd_reg(ESR_SEL_EVT, v);
        check(v, 16'h0020);
        check({8'h00, stb}, 16'h0000);
        $display("test event mask done");
        ctl_u.wr_reg(ESR_SEL_OPN, 16'h8001);
        cal = 1'b1;
        repeat (4) @(negedge mclk_i);
        ctl_u.rd_reg(ESR_SEL_OPN, v);
        check(v, 16'h0001);
        ctl_u.rd_reg(ESR_SEL_OPC, v);
        check(v, 16'h0001);
        check({8'h00, stb}, 16'h0080);
        ctl_u.rd_reg(ESR_SEL_OPE, v);
        check(v, 16'h0001);
        cal = 1'b0;
        repeat (4) @(negedge mclk_i);
        ctl_u.rd_reg(ESR_SEL_OPC, v);
        check(v, 16'h0000);
        $display("test operation done");
        ctl_u.wr_reg(ESR_SEL_QUN, 16'h0600);
        {onb, bl, tmp, lim, una} = 5'h1F;
        repeat (4) @(negedge mclk_i);
        ctl_u.rd_reg(ESR_SEL_QUC, v);
        check(v, 16'h0614);
        check({15'h0000, una_o_w}, 16'h0001);
        check({8'h00, stb}, 16'h0008);
        ctl_u.rd_reg(ESR_SEL_QUE, v);
        check(v, 16'h0614);
        ctl_u.rd_reg(ESR_SEL_QUE, v);
        check(v, 16'h0000);
        onb = 1'b0;
        repeat (4) @(negedge mclk_i);
        ctl_u.rd_reg(ESR_SEL_QUC, v);
        check(v, 16'h0610);
        $display("test questionable done");
        rst_i = 1'b1;
        repeat (2) @(negedge mclk_i);
        rst_i = 1'b0;
        ctl_u.rd_reg(ESR_SEL_EVT, v);
        check(v, 16'h0080);
        ctl_u.rd_reg(ESR_SEL_ENA, v);
        check(v, 16'h0000);
        $display("test reset done");
        end_of_test();
    end
endmodule : esr_status_bank_tb_top
`default_nettype wire
